// ---- shared/rtc_core_regs.vh ----
// Register offsets, field positions, reset values and timing figures
// of the calendar clock core. Definitions only; included by bare name.
`ifndef RTC_CORE_REGS_VH
`define RTC_CORE_REGS_VH

// Clock and time base
`define CLK_HZ 25000000
`define XTAL_HZ 32768
`define PROG_TIME_MS 10

// Register map, six-bit byte addresses
`define ADDR_W 6
`define ALM0_BASE 6'h00
`define ALM1_BASE 6'h08
`define CTRL_ADDR 6'h10
`define TIME_BASE 6'h30
`define STAT_ADDR 6'h3f
// Field index inside the time block and each alarm block
`define F_SEC 3'h0
`define F_MIN 3'h1
`define F_HOUR 3'h2
`define F_DATE 3'h3
`define F_MON 3'h4
`define F_YEAR 3'h5
`define F_DOW 3'h6
`define ALM_FIELDS 7

// Bit positions
`define ALM_EN_BIT 7
`define HR_MIL_BIT 7
`define HR_PM_BIT 5
`define CTRL_IRQ_EN 0
`define CTRL_RPT0 1
`define CTRL_RPT1 2
`define ST_AL1 6
`define ST_AL0 5
`define ST_BUSY 1
`define ST_FAIL 0

// Reset values
`define RST_SEC 8'h00
`define RST_DATE 8'h01
`define RST_MON 8'h01
`define RST_YEAR 8'h00
`define RST_HOUR 6'h12
`define RST_DOW 3'h0
`define RST_CTRL 8'h00

// Counter limits in BCD
`define MAX_SEC 8'h59
`define MAX_MON 8'h12
`define MAX_YEAR 8'h99
`define MAX_H24 6'h23
`define MAX_H12 6'h12
`define PM_ROLL_H12 6'h11
`define MIN_H12 6'h01
`define MAX_DOW 3'h6

`endif

// ---- src/alarm_matcher.v ----
// Compares one alarm block against the current time fields.
// Assumes both vectors hold fields in register order, one byte each.
`timescale 1ns/100ps
`include "rtc_core_regs.vh"

module alarm_matcher (
  input wire [8*`ALM_FIELDS-1:0] i_alarm,
  input wire [8*`ALM_FIELDS-1:0] i_time,
  output reg o_match
);

  integer k;
  reg any_en;
  reg all_eq;

  always @* begin
    any_en = 1'b0;
    all_eq = 1'b1;
    for (k = 0; k < `ALM_FIELDS; k = k + 1) begin
      if (i_alarm[8*k+`ALM_EN_BIT]) begin
        any_en = 1'b1;
        if (i_alarm[8*k +: 7] != i_time[8*k +: 7]) begin
          all_eq = 1'b0;
        end
      end
    end
    // No enabled field means no alarm at all
    o_match = any_en && all_eq;
  end

endmodule

// ---- src/bcd_roll_counter.v ----
// One BCD time field: counts from LOW up to a high limit, then wraps.
// Assumes load and increment come from logic on the same clock.
`timescale 1ns/100ps

module bcd_roll_counter #(
  parameter [7:0] LOW = 8'h00
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_inc,
  input wire i_load,
  input wire [7:0] i_load_val,
  input wire [7:0] i_high,
  output reg [7:0] o_value,
  output wire o_carry
);

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = v + 8'h01;
      end
    end
  endfunction

  // Carry leaves in the same cycle as the wrap
  assign o_carry = i_inc && (o_value == i_high);

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_value <= LOW;
    end else if (i_load) begin
      o_value <= i_load_val;
    end else if (i_inc) begin
      o_value <= (o_value == i_high) ? LOW : bcd_inc(o_value);
    end
  end

endmodule

// ---- src/calendar_clock_alarm_core.v ----
// Timekeeping core: calendar counters, two alarms, program-cycle timer,
// open-drain alarm line and a serial status peek on the two-wire pins.
// Assumes crystal and serial pins are asynchronous to i_clock; the
// register port is driven from i_clock logic.
//
// Contract
// R1 - After a nonvolatile write, run a self-timed program cycle of at most 10 ms.
// R2 - Master waits the full program cycle before the next access.
// R3 - Master waits up to 1 ms after power-up before reading.
// R4 - Master waits up to 5 ms after power-up before writing.
// R5 - Two independent alarms, each matching any clock or calendar value.
// R6 - Alarm match shows as status flag and, if enabled, on interrupt line.
// R7 - Repeat mode keeps an alarm armed so it recurs periodically.
// R8 - All serial data is clocked by the serial clock, never gated.
// R9 - Serial data line is only pulled low, open drain.
// R10 - Alarm is signalled by pulling the open-drain interrupt line low.
// R11 - Time base comes from the 32.768 kHz crystal.
// R12 - Separate second to year counts with carries field to field.
// R13 - Date wraps at true month end, with leap-year February.
// R14 - A control bit selects 24-hour or 12-hour with AM/PM.
// R15 - After total power loss counters stay halted until a clock write.
// R16 - Time fields are BCD within their documented ranges.
// R17 - Selector 1 means 24-hour; else PM flag reads 1 for PM, default AM.
// R18 - Weekday counter is three bits, cycles 0 to 6, defaults 0.
// R19 - Alarm field MSB enables it; all enables clear means no alarm.
// R20 - Crystal divided by 32768 gives the one-second tick.
// R21 - Alarms are compared once per second tick.
`timescale 1ns/100ps
`include "rtc_core_regs.vh"

module calendar_clock_alarm_core #(
  parameter XTAL_DIV = `XTAL_HZ,
  parameter PROG_CYCLES = `PROG_TIME_MS * (`CLK_HZ / 1000)
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_xtal,
  input wire [`ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_irq_out,
  output reg o_irq_oe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [5:0] bcd_inc6;
    input [5:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc6 = {v[5:4] + 2'h1, 4'h0};
      end else begin
        bcd_inc6 = v + 6'h01;
      end
    end
  endfunction

  function [7:0] month_end;
    input [7:0] mo;
    input [7:0] yr;
    reg leap;
    begin
      // Every fourth year; the century exception is not handled
      leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8))
        || (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
      case (mo)
        8'h02: month_end = leap ? 8'h29 : 8'h28;
        8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
        default: month_end = 8'h31;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Crystal sampling and one-second divider
  // ----------------------------------------------------------------
  reg xtal_s1;
  reg xtal_s2;
  reg xtal_s3;
  reg [15:0] xtal_cnt;
  reg sec_tick;
  reg tick_d;
  reg halted;

  always @(posedge i_clock) begin
    if (i_rst) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
      xtal_cnt <= 16'h0000;
      sec_tick <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      xtal_s1 <= i_xtal;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      sec_tick <= 1'b0;
      tick_d <= sec_tick;
      // Divider is held while halted so the first second is whole
      if (halted) begin
        xtal_cnt <= 16'h0000;
      end else if (xtal_s2 && !xtal_s3) begin  // see R11
        if (xtal_cnt == XTAL_DIV - 1) begin  // see R20
          xtal_cnt <= 16'h0000;
          sec_tick <= 1'b1;
        end else begin
          xtal_cnt <= xtal_cnt + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  wire time_wr = i_wr && (i_addr[5:3] == `TIME_BASE >> 3);
  wire alm_wr = i_wr && (i_addr[5:4] == 2'b00) && (i_addr[2:0] < `ALM_FIELDS);
  wire ctrl_wr = i_wr && (i_addr == `CTRL_ADDR);
  wire stat_wr = i_wr && (i_addr == `STAT_ADDR);
  reg prog_busy;
  // Nonvolatile writes are dropped while the program cycle runs
  wire nv_wr = (alm_wr || ctrl_wr) && !prog_busy;  // see R2

  // ----------------------------------------------------------------
  // Calendar counters
  // ----------------------------------------------------------------
  wire [7:0] sec;
  wire [7:0] minute;
  wire [7:0] date;
  wire [7:0] month;
  wire [7:0] year;
  wire sec_carry;
  wire min_carry;
  wire date_carry;
  wire mon_carry;
  reg [5:0] hour;
  reg pm;
  reg mil;
  reg [2:0] weekday_counter;
  reg day_carry;

  bcd_roll_counter #(.LOW(`RST_SEC)) u_sec (  // see R12
    .i_clock(i_clock), .i_rst(i_rst), .i_inc(sec_tick),
    .i_load(time_wr && i_addr[2:0] == `F_SEC), .i_load_val(i_wdata),
    .i_high(`MAX_SEC), .o_value(sec), .o_carry(sec_carry));

  bcd_roll_counter #(.LOW(`RST_SEC)) u_min (
    .i_clock(i_clock), .i_rst(i_rst), .i_inc(sec_carry),
    .i_load(time_wr && i_addr[2:0] == `F_MIN), .i_load_val(i_wdata),
    .i_high(`MAX_SEC), .o_value(minute), .o_carry(min_carry));

  bcd_roll_counter #(.LOW(`RST_DATE)) u_date (
    .i_clock(i_clock), .i_rst(i_rst), .i_inc(day_carry),
    .i_load(time_wr && i_addr[2:0] == `F_DATE), .i_load_val(i_wdata),
    .i_high(month_end(month, year)), .o_value(date),  // see R13
    .o_carry(date_carry));

  bcd_roll_counter #(.LOW(`RST_MON)) u_mon (
    .i_clock(i_clock), .i_rst(i_rst), .i_inc(date_carry),
    .i_load(time_wr && i_addr[2:0] == `F_MON), .i_load_val(i_wdata),
    .i_high(`MAX_MON), .o_value(month), .o_carry(mon_carry));

  bcd_roll_counter #(.LOW(`RST_YEAR)) u_year (  // see R16
    .i_clock(i_clock), .i_rst(i_rst), .i_inc(mon_carry),
    .i_load(time_wr && i_addr[2:0] == `F_YEAR), .i_load_val(i_wdata),
    .i_high(`MAX_YEAR), .o_value(year), .o_carry());

  // Day carry is combinational so the date steps with the hour at midnight, 23 to 00 or 11 PM to 12 AM
  always @* begin
    if (mil) begin
      day_carry = min_carry && (hour == `MAX_H24);
    end else begin
      day_carry = min_carry && pm && (hour == `PM_ROLL_H12);
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      hour <= `RST_HOUR;
      pm <= 1'b0;  // see R17
      mil <= 1'b0;
      weekday_counter <= `RST_DOW;
    end else begin
      if (time_wr && i_addr[2:0] == `F_HOUR) begin
        mil <= i_wdata[`HR_MIL_BIT];  // see R14
        if (i_wdata[`HR_MIL_BIT]) begin
          hour <= i_wdata[5:0];
          pm <= 1'b0;
        end else begin
          hour <= {1'b0, i_wdata[4:0]};
          pm <= i_wdata[`HR_PM_BIT];
        end
      end else if (min_carry) begin
        if (mil) begin
          hour <= (hour == `MAX_H24) ? 6'h00 : bcd_inc6(hour);
        end else begin
          hour <= (hour == `MAX_H12) ? `MIN_H12 : bcd_inc6(hour);
          if (hour == `PM_ROLL_H12) begin
            pm <= !pm;
          end
        end
      end
      if (time_wr && i_addr[2:0] == `F_DOW) begin
        weekday_counter <= i_wdata[2:0];
      end else if (day_carry) begin
        // see R18
        weekday_counter <= (weekday_counter == `MAX_DOW) ? 3'h0 : weekday_counter + 3'h1;
      end
    end
  end

  wire [7:0] hour_byte = {mil, 1'b0, mil ? hour : {pm, hour[4:0]}};

  // ----------------------------------------------------------------
  // Power-fail halt
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      halted <= 1'b1;
    end else if (time_wr) begin
      halted <= 1'b0;  // see R15
    end
  end

  // ----------------------------------------------------------------
  // Alarm and control storage, program cycle
  // ----------------------------------------------------------------
  reg [7:0] alarm_mem [0:15];
  reg [7:0] ctrl;
  reg [17:0] prog_cnt;
  integer n;

  always @(posedge i_clock) begin
    if (i_rst) begin
      for (n = 0; n < 16; n = n + 1) begin
        alarm_mem[n] <= 8'h00;
      end
      ctrl <= `RST_CTRL;
      prog_busy <= 1'b0;
      prog_cnt <= 18'h00000;
    end else begin
      if (nv_wr) begin
        if (alm_wr) begin
          alarm_mem[i_addr[3:0]] <= i_wdata;
        end else begin
          ctrl <= i_wdata;
        end
        prog_busy <= 1'b1;  // see R1
        prog_cnt <= 18'h00000;
      end else if (prog_busy) begin
        if (prog_cnt == PROG_CYCLES - 1) begin
          prog_busy <= 1'b0;
        end else begin
          prog_cnt <= prog_cnt + 18'h00001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm compare and flags
  // ----------------------------------------------------------------
  // Byte k of an alarm block lines up with time field k, weekday last
  wire [8*`ALM_FIELDS-1:0] time_vec = {{5'h00, weekday_counter}, year, month, date,
    hour_byte, minute, sec};
  wire [8*`ALM_FIELDS-1:0] alm0_vec = {alarm_mem[6], alarm_mem[5], alarm_mem[4],
    alarm_mem[3], alarm_mem[2], alarm_mem[1], alarm_mem[0]};
  wire [8*`ALM_FIELDS-1:0] alm1_vec = {alarm_mem[14], alarm_mem[13], alarm_mem[12],
    alarm_mem[11], alarm_mem[10], alarm_mem[9], alarm_mem[8]};
  wire match0;
  wire match1;
  reg alarm0_flag;
  reg alarm1_flag;
  reg armed0;
  reg armed1;

  alarm_matcher u_alm0 (.i_alarm(alm0_vec), .i_time(time_vec),  // see R5
    .o_match(match0));
  alarm_matcher u_alm1 (.i_alarm(alm1_vec), .i_time(time_vec),  // see R19
    .o_match(match1));

  // Compared the cycle after the tick, once the counters have moved
  wire fire0 = tick_d && match0 && armed0;  // see R21
  wire fire1 = tick_d && match1 && armed1;

  always @(posedge i_clock) begin
    if (i_rst) begin
      alarm0_flag <= 1'b0;
      alarm1_flag <= 1'b0;
      armed0 <= 1'b1;
      armed1 <= 1'b1;
    end else begin
      // Set wins over a write-one clear in the same cycle
      if (fire0) begin
        alarm0_flag <= 1'b1;  // see R6
      end else if (stat_wr && i_wdata[`ST_AL0]) begin
        alarm0_flag <= 1'b0;
      end
      if (fire1) begin
        alarm1_flag <= 1'b1;
      end else if (stat_wr && i_wdata[`ST_AL1]) begin
        alarm1_flag <= 1'b0;
      end
      // One-shot alarms disarm until their block is rewritten
      if (nv_wr && alm_wr && !i_addr[3]) begin
        armed0 <= 1'b1;
      end else if (fire0 && !ctrl[`CTRL_RPT0]) begin
        armed0 <= 1'b0;  // see R7
      end
      if (nv_wr && alm_wr && i_addr[3]) begin
        armed1 <= 1'b1;
      end else if (fire1 && !ctrl[`CTRL_RPT1]) begin
        armed1 <= 1'b0;
      end
    end
  end

  wire [7:0] status = {1'b0, alarm1_flag, alarm0_flag, 3'h0, prog_busy, halted};

  // ----------------------------------------------------------------
  // Register read and interrupt pin
  // ----------------------------------------------------------------
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_irq_out <= 1'b0;
      o_irq_oe <= 1'b0;
    end else begin
      o_irq_out <= 1'b0;
      // Pulled low while a flag is pending and enabled
      o_irq_oe <= ctrl[`CTRL_IRQ_EN] && (alarm0_flag || alarm1_flag);  // see R10
      if (i_rd) begin
        if (i_addr[5:3] == `TIME_BASE >> 3) begin
          case (i_addr[2:0])
            `F_SEC: o_rdata <= sec;
            `F_MIN: o_rdata <= minute;
            `F_HOUR: o_rdata <= hour_byte;
            `F_DATE: o_rdata <= date;
            `F_MON: o_rdata <= month;
            `F_YEAR: o_rdata <= year;
            `F_DOW: o_rdata <= {5'h00, weekday_counter};
            default: o_rdata <= 8'h00;
          endcase
        end else if (i_addr[5:4] == 2'b00 && i_addr[2:0] < `ALM_FIELDS) begin
          o_rdata <= alarm_mem[i_addr[3:0]];
        end else if (i_addr == `CTRL_ADDR) begin
          o_rdata <= ctrl;
        end else if (i_addr == `STAT_ADDR) begin
          o_rdata <= status;
        end else begin
          o_rdata <= 8'h00;
        end
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial status peek
  // ----------------------------------------------------------------
  reg scl_s1;
  reg scl_s2;
  reg scl_s3;
  reg sda_s1;
  reg sda_s2;
  reg sda_s3;
  reg [7:0] peek_shift;
  reg [3:0] peek_bits;

  wire scl_fall = scl_s3 && !scl_s2;
  wire bus_start = scl_s2 && sda_s3 && !sda_s2;
  wire bus_stop = scl_s2 && !sda_s3 && sda_s2;

  // After a start, the status byte is shifted out MSB first
  always @(posedge i_clock) begin
    if (i_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      peek_shift <= 8'h00;
      peek_bits <= 4'h0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      o_sda_out <= 1'b0;  // see R9
      if (bus_stop) begin
        peek_bits <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        peek_shift <= status;
        peek_bits <= 4'h8;
      end else if (scl_fall) begin  // see R8
        if (peek_bits != 4'h0) begin
          o_sda_oe <= !peek_shift[7];
          peek_shift <= {peek_shift[6:0], 1'b0};
          peek_bits <= peek_bits - 4'h1;
        end else begin
          o_sda_oe <= 1'b0;
        end
      end
    end
  end

endmodule

// ---- verification/calendar_clock_alarm_core_properties.sv ----
// Port-level assertions for the calendar clock core, bound onto its top.
// Assumes one clock domain and the register map header.
`timescale 1ns/100ps
`include "rtc_core_regs.vh"
module calendar_clock_alarm_core_checker #(
  parameter XTAL_DIV = 4,
  parameter PROG_CYCLES = 20
) (
  input wire i_clock,
  input wire i_rst,
  input wire i_xtal,
  input wire [`ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire i_scl,
  input wire i_sda,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_irq_out,
  input wire o_irq_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Loose bound: a dropped write restarts it too, never tightens it
  reg [31:0] since_nv;
  reg time_set;
  always @(posedge i_clock) begin
    if (i_rst) begin
      since_nv <= 32'h0;
      time_set <= 1'b0;
    end else begin
      since_nv <= (i_wr && i_addr <= `CTRL_ADDR) ? 32'h0 : since_nv + 32'h1;
      time_set <= time_set | (i_wr && i_addr >= `TIME_BASE && i_addr <= 6'h36);
    end
  end
  sequence ctrl_write;
    i_wr && i_addr == `CTRL_ADDR;
  endsequence
  sequence stat_read;
    i_rd && i_addr == `STAT_ADDR;
  endsequence
  AST_PULL_ONLY: assert property (!o_sda_out && !o_irq_out)
    else $error("open-drain drive value not low");
  AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  AST_UNMAPPED_ZERO: assert property (i_rd && i_addr[5:4] == 2'b10 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_SDA_AFTER_FALL: assert property ($rose(o_sda_oe) |-> !$past(i_scl))
    else $error("data pulled low while serial clock high");
  AST_PROG_BOUNDED: assert property (stat_read
    |=> !o_rdata[`ST_BUSY] || since_nv <= PROG_CYCLES + 4)
    else $error("program cycle too long");
  AST_BUSY_AFTER_CTRL: assert property (ctrl_write ##2 stat_read |=> o_rdata[`ST_BUSY])
    else $error("no program cycle after control write");
  AST_HALT_HOLDS: assert property (!time_set && i_rd && i_addr == `TIME_BASE
    |=> o_rdata == 8'h00)
    else $error("seconds moved while halted");
  AST_SEC_BCD: assert property (i_rd && i_addr == `TIME_BASE
    |=> o_rdata <= `MAX_SEC && o_rdata[3:0] <= 4'h9)
    else $error("seconds outside BCD range");
  AST_DOW_RANGE: assert property (i_rd && i_addr == 6'h36 |=> o_rdata <= 8'h06)
    else $error("weekday outside range");
  AST_IRQ_HAS_FLAG: assert property ((!i_wr) [*3] ##0 (o_irq_oe and stat_read)
    |=> o_rdata[`ST_AL1] || o_rdata[`ST_AL0])
    else $error("interrupt without alarm flag");
endmodule

bind calendar_clock_alarm_core calendar_clock_alarm_core_checker #(
  .XTAL_DIV(XTAL_DIV),
  .PROG_CYCLES(PROG_CYCLES)
) u_checker (
  .i_clock(i_clock), .i_rst(i_rst), .i_xtal(i_xtal), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe)
);

// ---- verification/calendar_clock_alarm_core_tb_top.sv ----
// Self-checking bench for the calendar clock core and a serial master.
// Assumes shortened divider and program counts set below.
`timescale 1ns/100ps
`include "rtc_core_regs.vh"
module calendar_clock_alarm_core_tb_top;
  localparam DIV = 4;
  localparam PROG = 20;
  localparam PUW = 50;
  localparam [55:0] RSTV = 56'h00_00_12_01_01_00_00;
  reg i_clock, i_rst, i_xtal, i_wr, i_rd;
  reg [5:0] i_addr;
  reg [7:0] i_wdata;
  reg [7:0] v;
  reg [7:0] t;
  wire [7:0] o_rdata;
  wire scl, sda, o_sda_out, o_sda_oe, o_irq_out, o_irq_oe;
  wire irq_line = ~o_irq_oe;
  integer seed = 52132;
  integer mismatches = 0;
  integer checked = 0;
  integer i, k, y, n;
  calendar_clock_alarm_core #(.XTAL_DIV(DIV), .PROG_CYCLES(PROG)) uut (
    .i_clock(i_clock), .i_rst(i_rst), .i_xtal(i_xtal), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl),
    .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_irq_out(o_irq_out),
    .o_irq_oe(o_irq_oe));
  two_wire_master_model #(.HALF(4)) u_master (.i_clock(i_clock), .i_sda_oe(o_sda_oe), .o_scl(scl),
    .o_sda(sda));
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Crystal runs free, phase unrelated to the core clock
  initial begin
    i_xtal = 1'b0;
    #7;
    forever #160 i_xtal = ~i_xtal;
  end
  function automatic [7:0] bcd(input integer x);
    bcd = 8'((x / 10) * 16 + x % 10);
  endfunction
  function automatic integer dec(input [7:0] b);
    dec = b[7:4] * 10 + b[3:0];
  endfunction
  function automatic integer mdays(input integer m, input integer yr);
    mdays = (m == 2) ? ((yr % 4 == 0) ? 29 : 28) : (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
  endfunction
  task automatic chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic report_and_stop;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task automatic hang;
    begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  endtask
  // ----
  // Register port
  // ----
  task automatic wr(input [5:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
    end
  endtask
  task automatic rd(input [5:0] a, output [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 d = o_rdata;
    end
  endtask
  task automatic wait_stat(input [7:0] mask, input [7:0] want, input integer lim);
    integer c;
    begin
      c = 0;
      rd(`STAT_ADDR, v);
      while ((v & mask) !== want && c < lim) begin
        rd(`STAT_ADDR, v);
        c = c + 1;
      end
      if ((v & mask) !== want) hang;
    end
  endtask
  // Polls the status register during the program cycle; returns once busy clears
  task automatic nv_wr(input [5:0] a, input [7:0] d);
    begin
      wr(a, d);
      rd(`STAT_ADDR, v);
      chk(v & 8'h02, 8'h02);
      wait_stat(8'h02, 8'h00, PROG);
    end
  endtask
  task automatic roll(input [7:0] hr, input [7:0] hr_exp, input integer d,
    input integer m, input integer yr, input integer w, input integer dayend);
    integer nd, nm, ny, j, c;
    reg [47:0] e;
    begin
      nd = dayend ? d + 1 : d;
      nm = m;
      ny = yr;
      if (nd > mdays(m, yr)) begin
        nd = 1;
        nm = m % 12 + 1;
        ny = (m == 12) ? (yr + 1) % 100 : yr;
      end
      // Seconds written last so no carry is lost between writes
      wr(6'h31, 8'h59);
      wr(6'h32, hr);
      wr(6'h33, bcd(d));
      wr(6'h34, bcd(m));
      wr(6'h35, bcd(yr));
      wr(6'h36, bcd(w));
      wr(`TIME_BASE, 8'h59);
      c = 0;
      v = 8'h59;
      while (v === 8'h59 && c < 100) begin
        rd(`TIME_BASE, v);
        c = c + 1;
      end
      if (c >= 100) hang;
      chk(v, 8'h00);
      e = {8'h00, hr_exp, bcd(nd), bcd(nm), bcd(ny), bcd(dayend ? (w + 1) % 7 : w)};
      for (j = 0; j < 6; j = j + 1) begin
        rd(6'h31 + j[5:0], v);
        chk(v, e[47 - 8 * j -: 8]);
      end
    end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 6'h00;
    i_wdata = 8'h00;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (PUW) @(posedge i_clock);
    for (i = 0; i < 7; i = i + 1) begin
      rd(`TIME_BASE + i[5:0], v);
      chk(v, RSTV[55 - 8 * i -: 8]);
    end
    rd(`STAT_ADDR, v);
    chk(v, 8'h01);
    wr(6'h20, 8'h5a);
    rd(6'h20, v);
    chk(v, 8'h00);
    repeat (200) @(posedge i_clock);
    rd(`TIME_BASE, v);
    chk(v, 8'h00);
    roll(8'ha3, 8'h80, 28, 2, 1, 6, 1);
    roll(8'ha3, 8'h80, 28, 2, 4, 0, 1);
    roll(8'h31, 8'h12, 31, 12, 99, 3, 1);
    roll(8'h11, 8'h32, 15, 6, 20, 2, 0);
    for (i = 0; i < 6; i = i + 1) begin
      k = 1 + {$random(seed)} % 12;
      y = {$random(seed)} % 100;
      roll(8'ha3, 8'h80, mdays(k, y), k, y, {$random(seed)} % 7, 1);
    end
    rd(`STAT_ADDR, v);
    chk(v, 8'h00);
    rd(`TIME_BASE, v);
    t = bcd((dec(v) + 5) % 60);
    nv_wr(`ALM0_BASE, 8'h80 | t);
    rd(6'h36, v);
    nv_wr(`ALM0_BASE + 6'h06, 8'h80 | v);
    nv_wr(`CTRL_ADDR, 8'h00);
    wait_stat(8'h20, 8'h20, 400);
    rd(`TIME_BASE, v);
    chk(v, t);
    chk({7'h0, irq_line}, 8'h01);
    rd(`STAT_ADDR, v);
    chk(v, 8'h20);
    u_master.peek(v);
    chk(v, 8'h20);
    chk({7'h0, sda}, 8'h01);
    wr(`STAT_ADDR, 8'h20);
    rd(`STAT_ADDR, v);
    chk(v, 8'h00);
    rd(`TIME_BASE, v);
    t = bcd((dec(v) + 5) % 60);
    nv_wr(`ALM1_BASE, 8'h80 | t);
    nv_wr(`CTRL_ADDR, 8'h05);
    for (k = 0; k < 2; k = k + 1) begin
      n = 0;
      while (irq_line !== 1'b0 && n < 2500) begin
        @(posedge i_clock);
        n = n + 1;
      end
      if (n >= 2500) hang;
      rd(`STAT_ADDR, v);
      chk(v, 8'h40);
      wr(`STAT_ADDR, 8'h40);
      repeat (4) @(posedge i_clock);
      chk({7'h0, irq_line}, 8'h01);
    end
    report_and_stop;
  end
endmodule

// ---- verification/two_wire_master_model.sv ----
// Serial bus master model that peeks the status byte over the pins.
// Assumes a pull-up on the data line; paced by the core clock.
`timescale 1ns/100ps
module two_wire_master_model #(
  parameter HALF = 20
) (
  input wire i_clock,
  input wire i_sda_oe,
  output reg o_scl,
  output wire o_sda
);
  reg pull_low;
  // Wired-AND with pull-up: a released line reads high
  assign o_sda = ~(pull_low | i_sda_oe);
  initial begin
    o_scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic half_wait;
    repeat (HALF) @(posedge i_clock);
  endtask
  // Clock idles high between frames and paces every bit
  task automatic peek(output [7:0] b);
    integer i;
    begin
      pull_low <= 1'b1;
      half_wait;
      o_scl <= 1'b0;
      half_wait;
      pull_low <= 1'b0;
      for (i = 7; i >= 0; i = i - 1) begin
        half_wait;
        o_scl <= 1'b1;
        half_wait;
        b[i] = o_sda;
        o_scl <= 1'b0;
      end
      half_wait;
      pull_low <= 1'b1;
      half_wait;
      o_scl <= 1'b1;
      half_wait;
      pull_low <= 1'b0;
      half_wait;
    end
  endtask
endmodule
